// [inc/gdfs_consts.svh]
// Constants for the gate driver fault supervisor
`ifndef GDFS_CONSTS_SVH
`define GDFS_CONSTS_SVH

// APB register byte addresses
`define GDFS_ADDR_CTRL 12'h000
`define GDFS_ADDR_STAT 12'h004
`define GDFS_ADDR_IRQ_STAT 12'h008
`define GDFS_ADDR_IRQ_MASK 12'h00C

// Control register fields
`define GDFS_CTRL_SW_CLEAR 0
`define GDFS_CTRL_FORCE_OFF 1
`define GDFS_CTRL_RESET 32'h0000_0000

// Status register fields
`define GDFS_STAT_FAULT 0
`define GDFS_STAT_READY 1
`define GDFS_STAT_LOCKOUT 2
`define GDFS_STAT_DRIVE 3
`define GDFS_STAT_CLAMP 4
`define GDFS_STAT_SOFT 5

// Interrupt bits
`define GDFS_IRQ_W 3
`define GDFS_IRQ_DESAT 0
`define GDFS_IRQ_LOCKOUT 1
`define GDFS_IRQ_READY_LOSS 2
`define GDFS_IRQ_RESET 3'h0

// Timing: blanking window and least soft shutdown time
`define GDFS_CLK_HZ 25000000
`define GDFS_BLANK_NS 3000
`define GDFS_BLANK_CYC ((`GDFS_BLANK_NS * 25 + 999) / 1000)
`define GDFS_SOFT_MIN_NS 200
`define GDFS_SOFT_MIN_CYC ((`GDFS_SOFT_MIN_NS * 25 + 999) / 1000)
`define GDFS_CNT_W 8

`endif

// [inc/gdfs_pkg.sv]
// Types of the gate driver fault supervisor
`default_nettype none
package gdfs_pkg;
  typedef enum logic [2:0] {
    GDFS_LOCKOUT,
    GDFS_RUN,
    GDFS_SOFT_OFF,
    GDFS_FAULT_HOLD
  } gdfs_state_t;

  typedef struct packed {
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [1:0] sync_d;
    gdfs_state_t state;
    logic [7:0] blank_cnt;
    logic [7:0] soft_cnt;
    logic drive;
    logic clamp;
    logic ready;
    logic fault_n_out;
    logic [1:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [31:0] prdata;
  } gdfs_regs_t;
endpackage
`default_nettype wire

// [logic/gdfs_top.sv]
// Fault supervisor and gate sequencing of an isolated gate driver
//
// The address map and the APB slave port were decided locally.
`include "gdfs_consts.svh"
`default_nettype none
module gdfs_top
  import gdfs_pkg::*;
#(
  parameter int BLANK_CYC = `GDFS_BLANK_CYC,
  parameter int SOFT_MIN_CYC = `GDFS_SOFT_MIN_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Controller side pins
  input wire logic drive_pos_i,
  input wire logic drive_neg_i,
  input wire logic fault_clear_n_i,
  output logic fault_n_out_o,
  output logic fault_n_out_oe_n_o,
  output logic ready_o,
  output logic irq_o,
  // Supply lockout comparators (high = in lockout, hysteresis is analog)
  input wire logic input_side_supply_lockout_i,
  input wire logic driver_supply_lockout_i,
  // Driver side comparators
  input wire logic desat_sense_high_i,
  input wire logic gate_below_ref_i,
  // Gate drive controls
  output logic gate_pullup_out_o,
  output logic gate_pullup_weak_o,
  output logic gate_pulldown_out_o,
  output logic miller_clamp_o,
  output logic blanking_cap_charge_o,
  output logic blanking_cap_discharge_o
);

  gdfs_regs_t r_ff;
  gdfs_regs_t nxt_r;

  // Synchronised views; element [1] is the second stage
  logic pos_s;
  logic neg_s;
  logic clr_n_s;
  logic in_lock_s;
  logic drv_lock_s;
  logic desat_s;
  logic gate_low_s;
  logic cmd_high;
  logic acc;
  logic rd_istat;
  logic [2:0] events;

  // First two stages of the comparator synchronisers
  logic lock_in_q1;
  logic lock_drv_q1;
  logic desat_q1;
  logic lock_in_q0;
  logic lock_drv_q0;
  logic desat_q0;

  assign pos_s = r_ff.sync_a[1];
  assign neg_s = r_ff.sync_b[1];
  assign clr_n_s = r_ff.sync_c[1];
  assign in_lock_s = r_ff.sync_a[2];
  assign drv_lock_s = r_ff.sync_b[2];
  assign desat_s = r_ff.sync_c[2];
  assign gate_low_s = r_ff.sync_d[1];

  // Complementary input pair; software may also hold the gate off
  assign cmd_high = pos_s && !neg_s && !r_ff.ctrl[`GDFS_CTRL_FORCE_OFF];

  assign acc = psel_i && penable_i;
  assign rd_istat = acc && !pwrite_i && paddr_i == `GDFS_ADDR_IRQ_STAT;

  // Single-cycle access phase keeps the slave simple
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o = r_ff.prdata;

  always_comb begin
    nxt_r = r_ff;
    events = 3'h0;
    // Pin synchronisers are two-stage: stage 0 feeds only stage 1. The lockout
    // and desat comparators pass the separate q0/q1 flops into the spare
    // bit [2] of these vectors, a third stage; the gate comparator has its own pair in sync_d.
    nxt_r.sync_a = {1'b0, r_ff.sync_a[0], drive_pos_i};
    nxt_r.sync_b = {1'b0, r_ff.sync_b[0], drive_neg_i};
    nxt_r.sync_c = {1'b0, r_ff.sync_c[0], fault_clear_n_i};
    nxt_r.sync_d = {r_ff.sync_d[0], gate_below_ref_i};
    nxt_r.sync_a[2] = lock_in_q1;
    nxt_r.sync_b[2] = lock_drv_q1;
    nxt_r.sync_c[2] = desat_q1;

    unique case (r_ff.state)
      GDFS_LOCKOUT: begin
        // Pull-down unconditionally while driver supply is low
        nxt_r.drive = 1'b0;
        if (!drv_lock_s) begin
          nxt_r.state = GDFS_RUN;
        end
      end
      GDFS_RUN: begin
        nxt_r.drive = cmd_high;
        // Blanking counts only while the gate is on; off resets it
        if (!r_ff.drive) begin
          nxt_r.blank_cnt = '0;
        end else if (r_ff.blank_cnt < 8'(BLANK_CYC)) begin
          nxt_r.blank_cnt = r_ff.blank_cnt + 8'h01;
        end
        if (r_ff.drive && r_ff.blank_cnt >= 8'(BLANK_CYC) && desat_s) begin
          nxt_r.state = GDFS_SOFT_OFF;
          nxt_r.drive = 1'b0;
          nxt_r.soft_cnt = '0;
          nxt_r.fault_n_out = 1'b0;
          events[`GDFS_IRQ_DESAT] = 1'b1;
        end
      end
      GDFS_SOFT_OFF: begin
        // Weak pull-down only, until gate reaches the low reference and SOFT_MIN_CYC has elapsed
        if (r_ff.soft_cnt < 8'(SOFT_MIN_CYC)) begin
          nxt_r.soft_cnt = r_ff.soft_cnt + 8'h01;
        end
        if (gate_low_s && r_ff.soft_cnt >= 8'(SOFT_MIN_CYC)) begin
          nxt_r.state = GDFS_FAULT_HOLD;
        end
      end
      GDFS_FAULT_HOLD: begin
        // Held low whatever the inputs do; clear waits for desat gone
        nxt_r.drive = 1'b0;
        if ((!clr_n_s || r_ff.ctrl[`GDFS_CTRL_SW_CLEAR]) && !desat_s) begin
          nxt_r.state = GDFS_RUN;
          nxt_r.fault_n_out = 1'b1;
          nxt_r.blank_cnt = '0;
        end
      end
      default: nxt_r.state = GDFS_LOCKOUT;
    endcase

    // Driver lockout overrides every state, including a latched fault
    if (drv_lock_s) begin
      if (r_ff.state != GDFS_LOCKOUT) begin
        events[`GDFS_IRQ_LOCKOUT] = 1'b1;
      end
      nxt_r.state = GDFS_LOCKOUT;
      nxt_r.drive = 1'b0;
      nxt_r.blank_cnt = '0;
      nxt_r.fault_n_out = 1'b0;
    end else if (r_ff.state == GDFS_LOCKOUT) begin
      nxt_r.fault_n_out = 1'b1;
    end

    // Clamp engages only once the gate is below reference while off
    nxt_r.clamp = !nxt_r.drive && gate_low_s &&
                  nxt_r.state != GDFS_SOFT_OFF;

    nxt_r.ready = !in_lock_s && !drv_lock_s;
    if (r_ff.ready && !nxt_r.ready) begin
      events[`GDFS_IRQ_READY_LOSS] = 1'b1;
    end

    // APB writes; the clear bit is a one-shot request
    nxt_r.ctrl[`GDFS_CTRL_SW_CLEAR] = 1'b0;
    if (acc && pwrite_i) begin
      unique case (paddr_i)
        `GDFS_ADDR_CTRL: nxt_r.ctrl = pwdata_i[1:0];
        `GDFS_ADDR_IRQ_MASK: nxt_r.irq_mask = pwdata_i[2:0];
        default: ;
      endcase
    end

    // Read clears sticky bits, but a new event in the same cycle wins
    if (rd_istat) begin
      nxt_r.irq_stat = events;
    end else begin
      nxt_r.irq_stat = r_ff.irq_stat | events;
    end

    // Read data registered in the setup cycle, valid in access phase
    nxt_r.prdata = '0;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        `GDFS_ADDR_CTRL: nxt_r.prdata[1:0] = r_ff.ctrl;
        `GDFS_ADDR_STAT: begin
          nxt_r.prdata[`GDFS_STAT_FAULT] = !r_ff.fault_n_out;
          nxt_r.prdata[`GDFS_STAT_READY] = r_ff.ready;
          nxt_r.prdata[`GDFS_STAT_LOCKOUT] = drv_lock_s;
          nxt_r.prdata[`GDFS_STAT_DRIVE] = r_ff.drive;
          nxt_r.prdata[`GDFS_STAT_CLAMP] = r_ff.clamp;
          nxt_r.prdata[`GDFS_STAT_SOFT] = r_ff.state == GDFS_SOFT_OFF;
        end
        `GDFS_ADDR_IRQ_STAT: nxt_r.prdata[2:0] = r_ff.irq_stat | events;
        `GDFS_ADDR_IRQ_MASK: nxt_r.prdata[2:0] = r_ff.irq_mask;
        default: ;
      endcase
    end
  end

  // Separate first/second stage flops; q1 is read only by the state copy
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      lock_in_q0 <= 1'b1;
      lock_drv_q0 <= 1'b1;
      desat_q0 <= 1'b0;
      lock_in_q1 <= 1'b1;
      lock_drv_q1 <= 1'b1;
      desat_q1 <= 1'b0;
    end else begin
      lock_in_q0 <= input_side_supply_lockout_i;
      lock_drv_q0 <= driver_supply_lockout_i;
      desat_q0 <= desat_sense_high_i;
      lock_in_q1 <= lock_in_q0;
      lock_drv_q1 <= lock_drv_q0;
      desat_q1 <= desat_q0;
    end
  end

  // State register; reset models lockout on both sides
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r_ff <= '0;
      r_ff.sync_a[2] <= 1'b1;
      r_ff.sync_b[2] <= 1'b1;
      r_ff.sync_c[1] <= 1'b1;
      r_ff.state <= GDFS_LOCKOUT;
      r_ff.ctrl <= 2'h0;
      r_ff.irq_stat <= `GDFS_IRQ_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Open-drain fault pin: enable low means pulling low
  assign fault_n_out_o = 1'b0;
  assign fault_n_out_oe_n_o = r_ff.fault_n_out;
  assign ready_o = r_ff.ready;
  assign irq_o = |(r_ff.irq_stat & r_ff.irq_mask);

  // Gate stage decode: strong pull-up only when driving high
  assign gate_pullup_out_o = r_ff.drive && r_ff.state == GDFS_RUN;
  assign gate_pullup_weak_o = r_ff.state == GDFS_SOFT_OFF;
  assign gate_pulldown_out_o = !gate_pullup_out_o &&
                               r_ff.state != GDFS_SOFT_OFF;
  assign miller_clamp_o = r_ff.clamp;
  assign blanking_cap_charge_o = r_ff.drive;
  assign blanking_cap_discharge_o = !r_ff.drive;

endmodule // gdfs_top
`default_nettype wire

// [bench/gdfs_assertions.sv]
// Concurrent checks on the fault supervisor pins
`default_nettype none
module gdfs_checker (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic fault_n_out_o,
  input wire logic fault_n_out_oe_n_o,
  input wire logic ready_o,
  input wire logic input_side_supply_lockout_i,
  input wire logic driver_supply_lockout_i,
  input wire logic gate_pullup_out_o,
  input wire logic gate_pullup_weak_o,
  input wire logic gate_pulldown_out_o,
  input wire logic miller_clamp_o,
  input wire logic blanking_cap_charge_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // Held long enough to pass the synchronisers
  sequence lock_s;
    driver_supply_lockout_i [*6];
  endsequence
  sequence any_lock_s;
    (input_side_supply_lockout_i || driver_supply_lockout_i) [*6];
  endsequence
  pin_low_only_a: assert property (fault_n_out_o == 1'b0)
    else $error("fault pin driven high");
  lock_fault_a: assert property (lock_s |-> !fault_n_out_oe_n_o)
    else $error("fault pin released in lockout");
  lock_pulldown_a: assert property (lock_s |-> gate_pulldown_out_o &&
    !gate_pullup_out_o && !gate_pullup_weak_o)
    else $error("gate not pulled down in lockout");
  ready_gate_a: assert property (any_lock_s |-> !ready_o)
    else $error("ready high during lockout");
  ready_drop_a: assert property ($rose(input_side_supply_lockout_i ||
    driver_supply_lockout_i) |-> ##[1:6] !ready_o)
    else $error("ready did not drop");
  charge_on_a: assert property (gate_pullup_out_o |-> blanking_cap_charge_o)
    else $error("charge source off while driving");
  soft_off_a: assert property (gate_pullup_weak_o |->
    !gate_pullup_out_o && !gate_pulldown_out_o)
    else $error("strong driver on in soft stage");
  soft_fault_a: assert property ($rose(gate_pullup_weak_o) |->
    ##[0:2] !fault_n_out_oe_n_o)
    else $error("soft stage without fault pin");
  clamp_after_a: assert property (miller_clamp_o |-> gate_pulldown_out_o &&
    !gate_pullup_out_o && !gate_pullup_weak_o)
    else $error("clamp with gate not pulled down");
endmodule // gdfs_checker
bind gdfs_top gdfs_checker gdfs_checker_i (.ref_clk_i, .reset_i,
  .fault_n_out_o, .fault_n_out_oe_n_o, .ready_o,
  .input_side_supply_lockout_i, .driver_supply_lockout_i,
  .gate_pullup_out_o, .gate_pullup_weak_o, .gate_pulldown_out_o,
  .miller_clamp_o, .blanking_cap_charge_o);
`default_nettype wire

// [bench/gdfs_stage_model.sv]
// Power stage model: gate level and collector sense
`default_nettype none
module gdfs_stage_model (
  input wire logic clk_i,
  input wire logic pullup_i,
  input wire logic pulldown_i,
  input wire logic weak_i,
  input wire logic overload_i,
  output logic desat_sense_high_o,
  output logic gate_below_ref_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int level = 0;
  // Gate charges on the pull-up and drains through either pull-down path
  always @(posedge clk_i) begin
    if (pullup_i && level < 3) level <= level + 1;
    else if ((pulldown_i || weak_i) && level > 0) level <= level - 1;
  end
  assign gate_below_ref_o = (level == 0);
  // Off, the discharge switch empties the cap, so sense only rises when on
  assign desat_sense_high_o = overload_i && pullup_i;
endmodule // gdfs_stage_model
`default_nettype wire

// [bench/gate_driver_fault_supervisor_tb.sv]
// Self-checking bench of the gate driver fault supervisor
`include "gdfs_consts.svh"
`default_nettype none
module gate_driver_fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pos = 0, neg = 0, clr_n = 1, lk_in = 0, lk_dr = 0, ovl = 0;
  logic pready, pslverr, fpin, fdrv, foe_n, rdy, irq, pu, puw, pd, mc;
  logic chg, dis, desat, below, saw = 0;
  int bad_count = 0, tests_run = 0, cyc = 0, exp_irq = 0;
  gdfs_top #(.BLANK_CYC(4), .SOFT_MIN_CYC(2)) gdfs_top_i (.ref_clk_i(clk),
    .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .drive_pos_i(pos),
    .drive_neg_i(neg), .fault_clear_n_i(clr_n), .fault_n_out_o(fdrv),
    .fault_n_out_oe_n_o(foe_n), .ready_o(rdy), .irq_o(irq),
    .input_side_supply_lockout_i(lk_in), .driver_supply_lockout_i(lk_dr),
    .desat_sense_high_i(desat), .gate_below_ref_i(below),
    .gate_pullup_out_o(pu), .gate_pullup_weak_o(puw),
    .gate_pulldown_out_o(pd), .miller_clamp_o(mc),
    .blanking_cap_charge_o(chg), .blanking_cap_discharge_o(dis));
  gdfs_stage_model gdfs_stage_model_i (.clk_i(clk), .pullup_i(pu),
    .pulldown_i(pd), .weak_i(puw), .overload_i(ovl),
    .desat_sense_high_o(desat), .gate_below_ref_o(below));
  // External pull-up on the open-drain fault line
  assign fpin = foe_n ? 1'b1 : fdrv;
  initial forever #20 clk = ~clk;
  // Hang guard and soft-stage watcher
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (puw === 1'b1) saw <= 1'b1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Request held until pready is sampled high; data taken at that edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    pen <= 0;
  endtask
  // Read-to-clear status compared with the bench's own event record
  task rd_irq;
    apb(0, `GDFS_ADDR_IRQ_STAT, 0);
    chk(rd, exp_irq, "irq status");
    exp_irq = 0;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wait_pin(input logic v);
    for (int i = 0; i < 60 && fpin !== v; i++) @(posedge clk);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hBA7A));
    step(5);
    rst <= 0;
    chk({fpin, rdy, pd}, 3'b001, "reset pins");
    wait_pin(1);
    step(2);
    chk({fpin, rdy}, 2'b11, "startup");
    apb(0, `GDFS_ADDR_CTRL, 0);
    chk(rd, `GDFS_CTRL_RESET, "ctrl reset");
    apb(0, `GDFS_ADDR_IRQ_MASK, 0);
    chk(rd, 0, "mask reset");
    apb(1, 12'h010, 32'hFFFFFFFF);
    apb(0, 12'h010, 0);
    chk(rd, 0, "unmapped");
    apb(0, `GDFS_ADDR_IRQ_STAT, 0);
    $display("test registers done");
    for (int i = 0; i < 20; i++) begin
      {pos, neg} <= 2'($urandom);
      step(4);
      chk({pu, chg}, {2{pos & ~neg}}, "drive pair");
    end
    $display("test drive done");
    apb(1, `GDFS_ADDR_IRQ_MASK, 32'(1 << `GDFS_IRQ_DESAT));
    saw <= 0;
    pos <= 1;
    neg <= 0;
    ovl <= 1;
    wait_pin(0);
    exp_irq = 1 << `GDFS_IRQ_DESAT;
    for (int i = 0; i < 60 && mc !== 1'b1; i++) @(posedge clk);
    chk(saw, 1, "soft stage");
    chk({mc, pd, pu}, 3'b110, "clamp");
    ovl <= 0;
    for (int i = 0; i < 10; i++) begin
      {pos, neg} <= 2'($urandom);
      step(1);
      chk({pu, fpin}, 0, "latched");
    end
    chk(irq, 1, "irq raised");
    rd_irq();
    step(1);
    chk(irq, 0, "irq cleared");
    rd_irq();
    pos <= 1;
    neg <= 0;
    clr_n <= 0;
    step(6);
    clr_n <= 1;
    wait_pin(1);
    step(4);
    chk({fpin, pu}, 2'b11, "cleared");
    pos <= 0;
    $display("test desat done");
    apb(1, `GDFS_ADDR_IRQ_MASK, 32'(1 << `GDFS_IRQ_LOCKOUT));
    lk_dr <= 1;
    step(8);
    chk({fpin, rdy, pd, irq}, 4'b0011, "driver lockout");
    lk_dr <= 0;
    wait_pin(1);
    step(4);
    chk({fpin, rdy}, 2'b11, "lockout release");
    exp_irq = (1 << `GDFS_IRQ_LOCKOUT) | (1 << `GDFS_IRQ_READY_LOSS);
    rd_irq();
    $display("test driver lockout done");
    apb(1, `GDFS_ADDR_IRQ_MASK, 0);
    lk_in <= 1;
    step(8);
    chk({fpin, rdy, irq}, 3'b100, "input lockout");
    lk_in <= 0;
    step(8);
    chk(rdy, 1, "ready back");
    $display("test input lockout done");
    report_and_stop();
  end
endmodule // gate_driver_fault_supervisor_tb
`default_nettype wire
